// File: sim/test_uart_channel_register_map.sv
// Purpose: self-checking bench for the channel register map
// Assumes: one request, then a sample just after the answering edge
// Notes: idle cycle between requests keeps strobes single-driven
`timescale 1ns/1ps
module test_uart_channel_register_map;
  import ucrm_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  ucrm_req_t req = '0;
  logic [7:0] rx_data, rx_data1, rx_data2, rx_data3, rx_stat0, rx_stat1;
  logic [7:0] isr_status, lsr_status, msr_status, fsr_status;
  logic [15:0] tx_count, rx_count;
  ucrm_cfg_t cfg, c0;
  ucrm_evt_t evt;
  logic [31:0] rdata, w;
  logic rvalid;
  integer fails = 0;
  integer n_tests = 0;
  integer seed = 32'ha4d3;
  logic [7:0] mdl [32];
  logic [7:0] msk [32];
  logic [7:0] md [3] = '{8'h00, 8'h01, 8'h09};
  logic [7:0] d;
  ucrm_regs u_dut (.clk_sys, .arst_n, .req, .rx_data, .rx_data1, .rx_data2,
    .rx_data3, .rx_stat0, .rx_stat1, .isr_status, .lsr_status, .msr_status,
    .fsr_status, .tx_count, .rx_count, .cfg, .evt, .rdata, .rvalid);
  ucrm_engine_model u_eng (.clk_sys, .arst_n, .evt, .rx_data, .rx_data1,
    .rx_data2, .rx_data3, .rx_stat0, .rx_stat1, .isr_status, .lsr_status,
    .msr_status, .fsr_status, .tx_count, .rx_count);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [159:0] e,
                     input logic [159:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic acc(input logic rd, input logic [4:0] a,
                     input logic [1:0] sz, input logic [31:0] wd);
    @(posedge clk_sys);
    req <= '{addr: a, size: sz, rd: rd, wr: !rd, wdata: wd};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rxr(input logic [4:0] a, input logic [1:0] sz,
                     input logic [31:0] e, input logic [1:0] pop);
    acc(1'b1, a, sz, 32'h0);
    chk("read", {1'b1, pop, e}, {rvalid, evt.rx_pop, rdata});
    chk("read strobes", {a == ucrm_off_fifo, a == ucrm_off_line,
        a == ucrm_off_mdrop}, {evt.isr_rd, evt.lsr_rd, evt.msr_rd});
    // let a pop reach the engine before the caller samples its lanes
    @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end
  initial begin
    msk = '{default: 8'hff};
    foreach (msk[k]) if (!(k inside {1, 3, 4, [7:13], [15:19]}))
      msk[k] = 8'h00;
    msk[3] = ucrm_mask_lcr;
    msk[11] = ucrm_mask_cpr;
    msk[12] = ucrm_mask_rmode;
    msk[15] = ucrm_mask_resend;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    // read reset values, write random bytes, read them back masked
    for (int p = 0; p < 3; p++) begin
      foreach (msk[k]) if (msk[k] != 8'h00) begin
        d = 8'($random(seed));
        acc(p != 1, 5'(k), ucrm_sz8, {24'h0, d});
        if (p == 1) mdl[k] = d & msk[k];
        else chk("rw reg", p ? mdl[k] : 8'h00, rdata);
      end
    end
    w = {rx_count, tx_count};
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      acc(1'b0, 5'h14 + 5'(k), ucrm_sz8, {24'h0, d});
      mdl[20 + k] = d;
      rxr(5'h14 + 5'(k), ucrm_sz8, {24'h0, w[8*k +: 8]}, 2'h0);
    end
    chk("flow chars", {mdl[20], mdl[21], mdl[22], mdl[23]},
        {cfg.resume_char_first, cfg.resume_char_second, cfg.pause_char_first, cfg.pause_char_second});
    c0 = cfg;
    acc(1'b0, ucrm_off_fsr, ucrm_sz8, 32'($random(seed)));
    acc(1'b0, ucrm_off_rxwin, ucrm_sz32, 32'($random(seed)));
    chk("cfg kept", c0, cfg);
    rxr(ucrm_off_rxwin, ucrm_sz32, {rx_stat1, rx_data1, rx_stat0, rx_data},
        2'h2);
    rxr(ucrm_off_rxwin, ucrm_sz16, {16'h0, rx_stat0, rx_data}, 2'h1);
    rxr(ucrm_off_data, ucrm_sz8, {24'h0, rx_data}, 2'h1);
    rxr(ucrm_off_txwin, ucrm_sz32, 32'h0, 2'h0);
    rxr(ucrm_off_mdrop, ucrm_sz8, {24'h0, msr_status}, 2'h0);
    foreach (md[m]) begin
      acc(1'b0, ucrm_off_mdrop, ucrm_sz8, {24'h0, md[m]});
      d = 8'($random(seed));
      acc(1'b0, ucrm_off_data, ucrm_sz8, {24'h0, d});
      chk("data char", {1'b1, md[m][0] & !md[m][3], d},
          {evt.tx_valid, evt.tx_char});
      acc(1'b0, ucrm_off_scratch, ucrm_sz8, {24'h0, d});
      chk("addr char", {md[m][0], md[m][0] ? {md[m][3], d} : 9'h0},
          {evt.tx_valid, evt.tx_char & {9{md[m][0]}}});
      rxr(ucrm_off_scratch, ucrm_sz8, {24'h0, d}, 2'h0);
    end
    for (int s = 0; s < 3; s++) begin
      w = $random(seed);
      acc(1'b0, ucrm_off_txwin, 2'(s), w);
      chk("tx window", {1'b1, 2'(s), w & (s == 2 ? 32'hffffffff :
          s == 1 ? 32'h0000ffff : 32'h000000ff)},
          {evt.tx_valid, evt.tx_lanes, evt.tx_word & (s == 2 ? 32'hffffffff :
          s == 1 ? 32'h0000ffff : 32'h000000ff)});
    end
    // pair lanes on wide writes and wide count reads
    w = $random(seed);
    acc(1'b0, ucrm_off_tcnt_lo, ucrm_sz16, w);
    acc(1'b0, ucrm_off_rcnt_lo, ucrm_sz16, ~w);
    chk("flow pair", {w[7:0], w[15:8], ~w[7:0], ~w[15:8]},
        {cfg.resume_char_first, cfg.resume_char_second, cfg.pause_char_first, cfg.pause_char_second});
    rxr(ucrm_off_tcnt_lo, ucrm_sz16, {16'h0, tx_count}, 2'h0);
    rxr(ucrm_off_rcnt_lo, ucrm_sz16, {16'h0, rx_count}, 2'h0);
    rxr(ucrm_off_rxwin1, ucrm_sz8, {24'h0, rx_data1}, 2'h0);
    rxr(ucrm_off_rxwin2, ucrm_sz8, {24'h0, rx_data2}, 2'h0);
    rxr(ucrm_off_rxwin3, ucrm_sz8, {24'h0, rx_data3}, 2'h0);
    // misaligned wide write is dropped, a byte at lane 1 is sent
    acc(1'b0, ucrm_off_txwin1, ucrm_sz16, w);
    chk("tx refused", 1'b0, evt.tx_valid);
    acc(1'b0, ucrm_off_txwin1, ucrm_sz8, w);
    chk("tx lane", {1'b1, w[7:0]}, {evt.tx_valid, evt.tx_char[7:0]});
    // write-only strobes and status reads, two of them with side effects
    d = 8'($random(seed));
    acc(1'b0, ucrm_off_fifo, ucrm_sz8, {24'h0, d});
    chk("fifo strobe", {1'b1, d & ucrm_mask_fcr},
        {evt.fcr_valid, evt.fcr_strobe});
    acc(1'b0, ucrm_off_line, ucrm_sz8, {24'h0, d});
    chk("toggle strobe", {1'b1, d}, {evt.str_valid, evt.str_data});
    rxr(ucrm_off_fifo, ucrm_sz8, {24'h0, isr_status}, 2'h0);
    rxr(ucrm_off_line, ucrm_sz8, {24'h0, lsr_status}, 2'h0);
    rxr(ucrm_off_fsr, ucrm_sz8, {24'h0, fsr_status}, 2'h0);
    // a mid-run reset clears the map and its first request is served
    arst_n <= 1'b0;
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rxr(ucrm_off_scratch, ucrm_sz8, 32'h0, 2'h0);
    give_verdict();
  end
endmodule // test_uart_channel_register_map

// File: sim/ucrm_engine_model.sv
// Purpose: serial engine stand-in feeding receive chars and status
// Assumes: chars advance only when the map reports them consumed
// Notes: char lanes always differ so a swapped char lane shows up; both status lanes are A5h at base 5Ah
`timescale 1ns/1ps
module ucrm_engine_model
  import ucrm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ucrm_evt_t evt,
  output logic [7:0] rx_data,
  output logic [7:0] rx_data1,
  output logic [7:0] rx_data2,
  output logic [7:0] rx_data3,
  output logic [7:0] rx_stat0,
  output logic [7:0] rx_stat1,
  output logic [7:0] isr_status,
  output logic [7:0] lsr_status,
  output logic [7:0] msr_status,
  output logic [7:0] fsr_status,
  output logic [15:0] tx_count,
  output logic [15:0] rx_count
);
  logic [7:0] base;
  // pops move the head, so a stale read gives a different byte
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      base <= 8'h5a;
    end else begin
      base <= base + 8'(evt.rx_pop);
    end
  end
  assign rx_data = base;
  assign rx_data1 = base ^ 8'h3c;
  assign rx_data2 = base + 8'h01;
  assign rx_data3 = base ^ 8'hc3;
  assign rx_stat0 = ~base;
  assign rx_stat1 = {base[3:0], base[7:4]};
  assign isr_status = base ^ 8'h11;
  assign lsr_status = base ^ 8'h22;
  assign msr_status = base ^ 8'h44;
  assign fsr_status = base & 8'h33;
  assign tx_count = {base, ~base};
  assign rx_count = {~base, base ^ 8'h0f};
endmodule // ucrm_engine_model

// File: sim/ucrm_regs_assertions.sv
// Purpose: port-level checks of the channel register map
// Assumes: answers one cycle after the taking edge
// Notes: bound to every ucrm_regs instance
`timescale 1ns/1ps
module ucrm_regs_checker
  import ucrm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ucrm_req_t req,
  input wire logic [7:0] rx_data,
  input wire logic [7:0] rx_stat0,
  input wire ucrm_cfg_t cfg,
  input wire ucrm_evt_t evt,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_read_answer;
    req.rd |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("no answer");
  property p_no_stray;
    !req.rd |=> !rvalid;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray answer");
  property p_data_char;
    req.wr && req.addr == ucrm_off_data
      |=> evt.tx_valid && evt.tx_char[7:0] == $past(req.wdata[7:0]);
  endproperty
  a_data_char: assert property (p_data_char) else $error("bad char");
  property p_ninth;
    req.wr && req.addr == ucrm_off_data && cfg.mdrop[ucrm_bit_mde]
      |=> evt.tx_char[8] == !$past(cfg.mdrop[ucrm_bit_nps]);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("bad ninth bit");
  property p_resend;
    req.wr && req.addr == ucrm_off_resend
      |=> cfg.resend == ($past(req.wdata[7:0]) & ucrm_mask_resend);
  endproperty
  a_resend: assert property (p_resend) else $error("bad resend");
  property p_rmode;
    req.wr && req.addr == ucrm_off_rmode
      |=> cfg.rmode == ($past(req.wdata[7:0]) & ucrm_mask_rmode);
  endproperty
  a_rmode: assert property (p_rmode) else $error("bad rmode");
  property p_ro_quiet;
    req.wr && (req.addr == ucrm_off_fsr || req.addr[4:2] == 3'h6)
      |=> $stable(cfg);
  endproperty
  a_ro_quiet: assert property (p_ro_quiet) else $error("cfg hit");
  property p_rx_word;
    req.rd && req.addr == ucrm_off_rxwin && req.size == ucrm_sz32
      |=> rdata[7:0] == $past(rx_data) && rdata[15:8] == $past(rx_stat0)
      && evt.rx_pop == 2'h2;
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("bad rx word");
  property p_tx_rd_zero;
    req.rd && req.addr[4:2] == 3'h7 |=> rdata == 32'h0 && evt.rx_pop == 2'h0;
  endproperty
  a_tx_rd_zero: assert property (p_tx_rd_zero)
    else $error("tx read");
  property p_tx_word;
    req.wr && req.addr == ucrm_off_txwin && req.size == ucrm_sz32
      |=> evt.tx_word == $past(req.wdata);
  endproperty
  a_tx_word: assert property (p_tx_word) else $error("bad tx word");
  c_addr: cover property (req.wr && req.addr == ucrm_off_scratch
    && cfg.mdrop[0]);
  c_rx32: cover property (req.rd && req.addr == ucrm_off_rxwin);
  c_tx32: cover property (req.wr && req.addr == ucrm_off_txwin);
endmodule // ucrm_regs_checker
bind ucrm_regs ucrm_regs_checker u_chk (.clk_sys, .arst_n, .req, .rx_data,
  .rx_stat0, .cfg, .evt, .rdata, .rvalid);

// File: src/ucrm_pkg.sv
// Purpose: constants and carriers for one serial channel register map
// Assumes: 32-bit local bus, five-bit channel address, 100 MHz clock
// Notes: width of an access is given by a two-bit size code on the bus
package ucrm_pkg;
  localparam int ucrm_aw = 5;
  localparam logic [4:0] ucrm_off_data = 5'h00;
  localparam logic [4:0] ucrm_off_ier = 5'h01;
  localparam logic [4:0] ucrm_off_fifo = 5'h02;
  localparam logic [4:0] ucrm_off_lcr = 5'h03;
  localparam logic [4:0] ucrm_off_mcr = 5'h04;
  localparam logic [4:0] ucrm_off_line = 5'h05;
  localparam logic [4:0] ucrm_off_mdrop = 5'h06;
  localparam logic [4:0] ucrm_off_scratch = 5'h07;
  localparam logic [4:0] ucrm_off_dll = 5'h08;
  localparam logic [4:0] ucrm_off_dlm = 5'h09;
  localparam logic [4:0] ucrm_off_efr = 5'h0a;
  localparam logic [4:0] ucrm_off_cpr = 5'h0b;
  localparam logic [4:0] ucrm_off_rmode = 5'h0c;
  localparam logic [4:0] ucrm_off_atr = 5'h0d;
  localparam logic [4:0] ucrm_off_fsr = 5'h0e;
  localparam logic [4:0] ucrm_off_resend = 5'h0f;
  localparam logic [4:0] ucrm_off_ttrig = 5'h10;
  localparam logic [4:0] ucrm_off_rtrig = 5'h11;
  localparam logic [4:0] ucrm_off_fup = 5'h12;
  localparam logic [4:0] ucrm_off_flo = 5'h13;
  localparam logic [4:0] ucrm_off_tcnt_lo = 5'h14;
  localparam logic [4:0] ucrm_off_tcnt_hi = 5'h15;
  localparam logic [4:0] ucrm_off_rcnt_lo = 5'h16;
  localparam logic [4:0] ucrm_off_rcnt_hi = 5'h17;
  localparam logic [4:0] ucrm_off_rxwin = 5'h18;
  localparam logic [4:0] ucrm_off_rxwin1 = 5'h19;
  localparam logic [4:0] ucrm_off_rxwin2 = 5'h1a;
  localparam logic [4:0] ucrm_off_rxwin3 = 5'h1b;
  localparam logic [4:0] ucrm_off_txwin = 5'h1c;
  localparam logic [4:0] ucrm_off_txwin1 = 5'h1d;
  // writable masks; zero bits of the resend, rmode, lcr and cpr masks read zero
  localparam logic [7:0] ucrm_mask_resend = 8'h33;
  localparam logic [7:0] ucrm_mask_rmode = 8'h11;
  localparam logic [7:0] ucrm_mask_mdrop = 8'h0b;
  localparam logic [7:0] ucrm_mask_lcr = 8'h7f;
  localparam logic [7:0] ucrm_mask_cpr = 8'h13;
  localparam logic [7:0] ucrm_mask_fcr = 8'h07;
  localparam int ucrm_bit_mde = 0;
  localparam int ucrm_bit_nps = 3;
  localparam logic [7:0] ucrm_rst = 8'h00;
  // access size codes
  localparam logic [1:0] ucrm_sz8 = 2'h0;
  localparam logic [1:0] ucrm_sz16 = 2'h1;
  localparam logic [1:0] ucrm_sz32 = 2'h2;

  typedef struct packed {
    logic [4:0] addr;
    logic [1:0] size;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } ucrm_req_t;

  typedef struct packed {
    logic [7:0] interrupt_enables;
    logic [7:0] line_format;
    logic [7:0] modem_control;
    logic [7:0] mdrop;
    logic [7:0] scratch;
    logic [7:0] dll;
    logic [7:0] baud_divisor_high;
    logic [7:0] enhanced_features;
    logic [7:0] clock_prescale;
    logic [7:0] rmode;
    logic [7:0] auto_direction_toggle;
    logic [7:0] resend;
    logic [7:0] ttrig;
    logic [7:0] rtrig;
    logic [7:0] fup;
    logic [7:0] flo;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
  } ucrm_cfg_t;

  typedef struct packed {
    logic tx_valid;
    logic [8:0] tx_char;
    logic [1:0] tx_lanes;
    logic [31:0] tx_word;
    logic [7:0] fcr_strobe;
    logic fcr_valid;
    logic [7:0] str_data;
    logic str_valid;
    logic [1:0] rx_pop;
    logic lsr_rd;
    logic msr_rd;
    logic isr_rd;
  } ucrm_evt_t;

  typedef struct packed {
    ucrm_cfg_t cfg;
    ucrm_evt_t evt;
    logic [31:0] rdata;
    logic rvalid;
  } ucrm_state_t;
endpackage

// File: src/ucrm_regs.sv
// Purpose: register map and decode for one serial channel
// Assumes: one request per cycle, read data one cycle after the strobe
// Notes: core status is supplied by the serial engine on plain inputs
`timescale 1ns/1ps
module ucrm_regs
  import ucrm_pkg::*;
#(
  parameter int aw = ucrm_aw
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ucrm_req_t req,
  input wire logic [7:0] rx_data,
  input wire logic [7:0] rx_data1,
  input wire logic [7:0] rx_data2,
  input wire logic [7:0] rx_data3,
  input wire logic [7:0] rx_stat0,
  input wire logic [7:0] rx_stat1,
  input wire logic [7:0] isr_status,
  input wire logic [7:0] lsr_status,
  input wire logic [7:0] msr_status,
  input wire logic [7:0] fsr_status,
  input wire logic [15:0] tx_count,
  input wire logic [15:0] rx_count,
  output ucrm_cfg_t cfg,
  output ucrm_evt_t evt,
  output logic [31:0] rdata,
  output logic rvalid
);
  // ********************************
  // state
  // ********************************
  ucrm_state_t st;
  ucrm_state_t next_st;
  logic mde;
  logic [aw-1:0] a;

  // decode compares five-bit offsets; another width cannot be served
  if (aw != ucrm_aw) begin : g_aw_check
    $error("address width must be five bits");
  end
  assign mde = st.cfg.mdrop[ucrm_bit_mde];
  assign a = req.addr;
  assign cfg = st.cfg;
  assign evt = st.evt;
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;

  // ********************************
  // write decode
  // ********************************
  always_comb begin
    next_st = st;
    next_st.evt = '0;
    next_st.rvalid = req.rd;
    next_st.rdata = '0;
    if (req.wr) begin
      if (a == ucrm_off_data) begin
        next_st.evt.tx_valid = 1'b1;
        next_st.evt.tx_lanes = ucrm_sz8;
        next_st.evt.tx_char = {1'b0, req.wdata[7:0]};
        if (mde) begin
          // ninth bit marks a data byte
          next_st.evt.tx_char[8] = ~st.cfg.mdrop[ucrm_bit_nps];
        end
      end else if (a == ucrm_off_ier) begin
        next_st.cfg.interrupt_enables = req.wdata[7:0];
      end else if (a == ucrm_off_fifo) begin
        next_st.evt.fcr_valid = 1'b1;
        next_st.evt.fcr_strobe = req.wdata[7:0] & ucrm_mask_fcr;
      end else if (a == ucrm_off_lcr) begin
        next_st.cfg.line_format = req.wdata[7:0] & ucrm_mask_lcr;
      end else if (a == ucrm_off_mcr) begin
        next_st.cfg.modem_control = req.wdata[7:0];
      end else if (a == ucrm_off_line) begin
        next_st.evt.str_valid = 1'b1;
        next_st.evt.str_data = req.wdata[7:0];
      end else if (a == ucrm_off_mdrop) begin
        next_st.cfg.mdrop = req.wdata[7:0] & ucrm_mask_mdrop;
      end else if (a == ucrm_off_scratch) begin
        // same byte store; in 9-bit mode it also sends an address byte
        next_st.cfg.scratch = req.wdata[7:0];
        if (mde) begin
          next_st.evt.tx_valid = 1'b1;
          next_st.evt.tx_lanes = ucrm_sz8;
          next_st.evt.tx_char = {st.cfg.mdrop[ucrm_bit_nps],
                                 req.wdata[7:0]};
        end
      end else if (a == ucrm_off_dll) begin
        next_st.cfg.dll = req.wdata[7:0];
      end else if (a == ucrm_off_dlm) begin
        next_st.cfg.baud_divisor_high = req.wdata[7:0];
      end else if (a == ucrm_off_efr) begin
        next_st.cfg.enhanced_features = req.wdata[7:0];
      end else if (a == ucrm_off_cpr) begin
        next_st.cfg.clock_prescale = req.wdata[7:0] & ucrm_mask_cpr;
      end else if (a == ucrm_off_rmode) begin
        next_st.cfg.rmode = req.wdata[7:0] & ucrm_mask_rmode;
      end else if (a == ucrm_off_atr) begin
        next_st.cfg.auto_direction_toggle = req.wdata[7:0];
      end else if (a == ucrm_off_resend) begin
        next_st.cfg.resend = req.wdata[7:0] & ucrm_mask_resend;
      end else if (a == ucrm_off_ttrig) begin
        next_st.cfg.ttrig = req.wdata[7:0];
      end else if (a == ucrm_off_rtrig) begin
        next_st.cfg.rtrig = req.wdata[7:0];
      end else if (a == ucrm_off_fup) begin
        next_st.cfg.fup = req.wdata[7:0];
      end else if (a == ucrm_off_flo) begin
        next_st.cfg.flo = req.wdata[7:0];
      end else if (a == ucrm_off_tcnt_lo) begin
        next_st.cfg.resume_char_first = req.wdata[7:0];
        if (req.size != ucrm_sz8) begin
          next_st.cfg.resume_char_second = req.wdata[15:8];
        end
      end else if (a == ucrm_off_tcnt_hi) begin
        next_st.cfg.resume_char_second = req.wdata[7:0];
      end else if (a == ucrm_off_rcnt_lo) begin
        next_st.cfg.pause_char_first = req.wdata[7:0];
        if (req.size != ucrm_sz8) begin
          next_st.cfg.pause_char_second = req.wdata[15:8];
        end
      end else if (a == ucrm_off_rcnt_hi) begin
        next_st.cfg.pause_char_second = req.wdata[7:0];
      end else if (a >= ucrm_off_txwin) begin
        // one lane per offset; wider writes only from the window start 1Ch
        next_st.evt.tx_valid = 1'b1;
        next_st.evt.tx_word = req.wdata;
        next_st.evt.tx_lanes = req.size;
        next_st.evt.tx_char = {1'b0, req.wdata[7:0]};
        if (req.size == ucrm_sz16 && a != ucrm_off_txwin) begin
          next_st.evt.tx_valid = 1'b0;
        end
        if (req.size == ucrm_sz32 && a != ucrm_off_txwin) begin
          next_st.evt.tx_valid = 1'b0;
        end
      end
      // 0Eh and 18h-1Bh are read-only: writes dropped
    end

    // ********************************
    // read decode
    // ********************************
    if (req.rd) begin
      if (a == ucrm_off_data) begin
        next_st.rdata[7:0] = rx_data;
        next_st.evt.rx_pop = 2'h1;
      end else if (a == ucrm_off_ier) begin
        next_st.rdata[7:0] = st.cfg.interrupt_enables;
      end else if (a == ucrm_off_fifo) begin
        next_st.rdata[7:0] = isr_status;
        next_st.evt.isr_rd = 1'b1;
      end else if (a == ucrm_off_lcr) begin
        next_st.rdata[7:0] = st.cfg.line_format;
      end else if (a == ucrm_off_mcr) begin
        next_st.rdata[7:0] = st.cfg.modem_control;
      end else if (a == ucrm_off_line) begin
        next_st.rdata[7:0] = lsr_status;
        next_st.evt.lsr_rd = 1'b1;
      end else if (a == ucrm_off_mdrop) begin
        next_st.rdata[7:0] = msr_status;
        next_st.evt.msr_rd = 1'b1;
      end else if (a == ucrm_off_scratch) begin
        next_st.rdata[7:0] = st.cfg.scratch;
      end else if (a == ucrm_off_dll) begin
        next_st.rdata[7:0] = st.cfg.dll;
      end else if (a == ucrm_off_dlm) begin
        next_st.rdata[7:0] = st.cfg.baud_divisor_high;
      end else if (a == ucrm_off_efr) begin
        next_st.rdata[7:0] = st.cfg.enhanced_features;
      end else if (a == ucrm_off_cpr) begin
        next_st.rdata[7:0] = st.cfg.clock_prescale;
      end else if (a == ucrm_off_rmode) begin
        next_st.rdata[7:0] = st.cfg.rmode;
      end else if (a == ucrm_off_atr) begin
        next_st.rdata[7:0] = st.cfg.auto_direction_toggle;
      end else if (a == ucrm_off_fsr) begin
        next_st.rdata[7:0] = fsr_status;
      end else if (a == ucrm_off_resend) begin
        next_st.rdata[7:0] = st.cfg.resend;
      end else if (a == ucrm_off_ttrig) begin
        next_st.rdata[7:0] = st.cfg.ttrig;
      end else if (a == ucrm_off_rtrig) begin
        next_st.rdata[7:0] = st.cfg.rtrig;
      end else if (a == ucrm_off_fup) begin
        next_st.rdata[7:0] = st.cfg.fup;
      end else if (a == ucrm_off_flo) begin
        next_st.rdata[7:0] = st.cfg.flo;
      end else if (a == ucrm_off_tcnt_lo) begin
        next_st.rdata[15:0] = tx_count;
        if (req.size == ucrm_sz8) begin
          next_st.rdata[15:8] = 8'h00;
        end
      end else if (a == ucrm_off_tcnt_hi) begin
        next_st.rdata[7:0] = tx_count[15:8];
      end else if (a == ucrm_off_rcnt_lo) begin
        next_st.rdata[15:0] = rx_count;
        if (req.size == ucrm_sz8) begin
          next_st.rdata[15:8] = 8'h00;
        end
      end else if (a == ucrm_off_rcnt_hi) begin
        next_st.rdata[7:0] = rx_count[15:8];
      end else if (a == ucrm_off_rxwin) begin
        // 16-bit: char + status; 32-bit: char,status,char,status
        next_st.rdata[7:0] = rx_data;
        next_st.evt.rx_pop = 2'h1;
        if (req.size == ucrm_sz16) begin
          next_st.rdata[15:8] = rx_stat0;
        end else if (req.size == ucrm_sz32) begin
          next_st.rdata = {rx_stat1, rx_data1, rx_stat0, rx_data};
          next_st.evt.rx_pop = 2'h2;
        end
      end else if (a == ucrm_off_rxwin1) begin
        next_st.rdata[7:0] = rx_data1;
      end else if (a == ucrm_off_rxwin2) begin
        next_st.rdata[7:0] = rx_data2;
      end else if (a == ucrm_off_rxwin3) begin
        next_st.rdata[7:0] = rx_data3;
      end
      // transmit window reads as zero and pops nothing
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // ucrm_regs
